//--- design/lsw_pkg.sv
// Package with timing constants and state encodings for the load switch fault controller
package lsw_pkg;
  localparam int unsigned CLK_FREQ_HZ = 250_000_000;
  localparam int unsigned TICK_PERIOD_NS = 1000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_DIV_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned BLANK_TIME_MS = 7;
  localparam int unsigned RETRY_TIME_MS = 150;
  localparam int unsigned BLANK_TICKS = BLANK_TIME_MS * 1000;
  localparam int unsigned RETRY_TICKS = RETRY_TIME_MS * 1000;
  localparam int unsigned TICK_CNT_W = 18;
  localparam int unsigned DIV_CNT_W = 8;
  localparam logic [TICK_CNT_W-1:0] TICK_CNT_RST = 18'h00000;
  localparam logic [DIV_CNT_W-1:0] DIV_CNT_RST = 8'h00;
  localparam logic [2:0] SYNC_RST = 3'h0;

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_ON = 5'h02,
    ST_LIMIT = 5'h04,
    ST_RETRY = 5'h08,
    ST_LATCHED = 5'h10
  } sw_state_t;
endpackage : lsw_pkg

//--- design/lsw_tick_if.sv
// Interface carrying the time base tick between the time base and the controller
`timescale 1ns/1ps
interface lsw_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : lsw_tick_if

//--- design/lsw_timebase.sv
// Free-running time base producing a one-cycle tick every microsecond
`timescale 1ns/1ps
module lsw_timebase (
  input wire logic clk,
  input wire logic rst_n,
  lsw_tick_if.src tb
);
  logic [lsw_pkg::DIV_CNT_W-1:0] div_ff;
  logic tick_ff;
  wire div_wrap = (div_ff == lsw_pkg::DIV_CNT_W'(lsw_pkg::TICK_DIV_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_ff <= lsw_pkg::DIV_CNT_RST;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= div_wrap ? lsw_pkg::DIV_CNT_RST : div_ff + 8'h01;
      tick_ff <= div_wrap;
    end
  end

  assign tb.tick = tick_ff;
endmodule : lsw_timebase

//--- design/load_switch_fault_controller.sv
// Fault handling controller for a load switch: limit, shutdown, latch or retry, flags
`timescale 1ns/1ps
// Summary of operation
// (R01) Over-current detected: enter current limiting at once, before any shutdown timing.
// (R02) Over-current lasting over 7 ms: switch off and pull fault flag low.
// (R03) Auto-retry: stay off 150 ms after over-current, then on only if enable high.
// (R04) Latching: stay off after over-current until enable toggles or power returns.
// (R05) Host holds enable high to activate; low enable keeps switch inactive.
// (R06) Fault flag is open drain, driven low while a fault is active.
// (R07) Power-good open drain pulled low once output passes 90 % of input while the switch is on.
// (R08) Over-temperature turns the switch off at once in both variants.
// (R09) Auto-retry: restart 150 ms after temperature is normal; flag low meanwhile.
// (R10) Auto-retry: fault flag released 150 ms after over-temperature ends.
// (R11) Latching: over-temperature leaves switch off, no retry, flag stays low.
// (R12) Blanking and retry intervals counted in ticks of an internal time base.
// (R13) Latching or auto-retry chosen by a build-time parameter.
module load_switch_fault_controller #(
  parameter bit AUTO_RETRY = 1'b1,
  parameter int unsigned BLANK_TICKS = lsw_pkg::BLANK_TICKS,
  parameter int unsigned RETRY_TICKS = lsw_pkg::RETRY_TICKS
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Host control
  input wire logic EN,
  // Analog detector inputs
  input wire logic OVER_CURRENT,
  input wire logic OVER_TEMPERATURE,
  input wire logic VOUT_ABOVE_90PCT,
  // Switch drive
  output logic SWITCH_ON,
  output logic CURRENT_LIMIT,
  // Open-drain fault flag
  output logic FAULT_FLAG_N_O,
  output logic FAULT_FLAG_N_OE_N,
  // Open-drain power good
  output logic POWER_GOOD_OUT_O,
  output logic POWER_GOOD_OUT_OE_N
);
  lsw_tick_if tb_if ();

  lsw_timebase u_timebase (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .tb(tb_if.src)
  ); // see (R12)

  // Three-stage synchronisers; a change counts when stages two and three agree
  logic [2:0] en_sync_ff, oc_sync_ff, ot_sync_ff, pg_sync_ff;
  logic en_ff, oc_ff, ot_ff, pg_ff;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      en_sync_ff <= lsw_pkg::SYNC_RST;
      oc_sync_ff <= lsw_pkg::SYNC_RST;
      ot_sync_ff <= lsw_pkg::SYNC_RST;
      pg_sync_ff <= lsw_pkg::SYNC_RST;
    end else begin
      en_sync_ff <= {en_sync_ff[1:0], EN};
      oc_sync_ff <= {oc_sync_ff[1:0], OVER_CURRENT};
      ot_sync_ff <= {ot_sync_ff[1:0], OVER_TEMPERATURE};
      pg_sync_ff <= {pg_sync_ff[1:0], VOUT_ABOVE_90PCT};
    end
  end

  wire en_agree = en_sync_ff[1] == en_sync_ff[2];
  wire oc_agree = oc_sync_ff[1] == oc_sync_ff[2];
  wire ot_agree = ot_sync_ff[1] == ot_sync_ff[2];
  wire pg_agree = pg_sync_ff[1] == pg_sync_ff[2];

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      en_ff <= 1'b0;
      oc_ff <= 1'b0;
      ot_ff <= 1'b0;
      pg_ff <= 1'b0;
    end else begin
      if (en_agree) en_ff <= en_sync_ff[2];
      if (oc_agree) oc_ff <= oc_sync_ff[2];
      if (ot_agree) ot_ff <= ot_sync_ff[2];
      if (pg_agree) pg_ff <= pg_sync_ff[2];
    end
  end

  // Controller state
  lsw_pkg::sw_state_t state_ff, nxt_state;
  lsw_pkg::sw_state_t fault_state;
  logic [lsw_pkg::TICK_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic en_prev_ff;
  logic ot_seen_ff, nxt_ot_seen;

  // Edge detector starts low, matching enable after reset, so no false toggle follows
  wire en_fall = en_prev_ff & ~en_ff;
  wire tick = tb_if.tick;
  wire [lsw_pkg::TICK_CNT_W-1:0] cnt_inc = cnt_ff + 18'h00001;
  // Blanking may end up to one tick late; the tick phase is not aligned to the event
  wire blank_done = tick && (cnt_ff >= lsw_pkg::TICK_CNT_W'(BLANK_TICKS)); // see (R02)
  wire retry_done = tick && (cnt_ff >= lsw_pkg::TICK_CNT_W'(RETRY_TICKS - 1));
  // Variant fixed at build time; nothing at run time can change it
  assign fault_state = AUTO_RETRY ? lsw_pkg::ST_RETRY : lsw_pkg::ST_LATCHED; // see (R13)

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_ot_seen = ot_seen_ff;
    case (state_ff)
      lsw_pkg::ST_OFF: begin
        nxt_cnt = lsw_pkg::TICK_CNT_RST;
        if (en_ff && !ot_ff) nxt_state = lsw_pkg::ST_ON; // see (R05)
      end
      lsw_pkg::ST_ON: begin
        // Counter held cleared so the blanking window starts from zero on entry
        nxt_cnt = lsw_pkg::TICK_CNT_RST;
        if (ot_ff) begin
          nxt_ot_seen = 1'b1;
          nxt_state = fault_state; // see (R08)
        end else if (!en_ff) begin
          nxt_state = lsw_pkg::ST_OFF; // see (R05)
        end else if (oc_ff) begin
          nxt_state = lsw_pkg::ST_LIMIT; // see (R01)
        end
      end
      lsw_pkg::ST_LIMIT: begin
        if (tick) nxt_cnt = cnt_inc;
        if (ot_ff) begin
          nxt_ot_seen = 1'b1;
          nxt_cnt = lsw_pkg::TICK_CNT_RST;
          nxt_state = fault_state; // see (R08)
        end else if (!en_ff) begin
          nxt_state = lsw_pkg::ST_OFF;
        end else if (!oc_ff) begin
          // Window must be continuous: a dropout forgets the time spent limiting
          nxt_state = lsw_pkg::ST_ON;
        end else if (blank_done) begin
          nxt_ot_seen = 1'b0;
          nxt_cnt = lsw_pkg::TICK_CNT_RST;
          nxt_state = fault_state; // see (R02) (R03) (R04)
        end
      end
      lsw_pkg::ST_RETRY: begin
        // Hold-off restarts while hot, so it counts from the end of the thermal event
        if (ot_ff) begin
          nxt_cnt = lsw_pkg::TICK_CNT_RST; // see (R09)
        end else if (retry_done) begin
          nxt_cnt = lsw_pkg::TICK_CNT_RST;
          nxt_ot_seen = 1'b0;
          // Enable is looked at only here; a low enable lands in off with no fault
          nxt_state = en_ff ? lsw_pkg::ST_ON : lsw_pkg::ST_OFF; // see (R03) (R10)
        end else if (tick) begin
          nxt_cnt = cnt_inc;
        end
      end
      lsw_pkg::ST_LATCHED: begin
        nxt_cnt = lsw_pkg::TICK_CNT_RST;
        // Toggle clears only when not still hot; power cycling is the reset
        if (en_fall && !ot_ff) begin
          nxt_ot_seen = 1'b0;
          nxt_state = lsw_pkg::ST_OFF; // see (R04) (R11)
        end
      end
      default: begin
        // Codes that are not one-hot fall back to off with the switch open
        nxt_state = lsw_pkg::ST_OFF;
        nxt_cnt = lsw_pkg::TICK_CNT_RST;
        nxt_ot_seen = 1'b0;
      end
    endcase
  end

  // Next-state decode; outputs register from it so they move with the state
  wire nxt_is_on = (nxt_state == lsw_pkg::ST_ON);
  wire nxt_is_limit = (nxt_state == lsw_pkg::ST_LIMIT);
  wire nxt_is_retry = (nxt_state == lsw_pkg::ST_RETRY);
  wire nxt_is_latched = (nxt_state == lsw_pkg::ST_LATCHED);
  wire nxt_sw_on = nxt_is_on || nxt_is_limit;
  wire nxt_limit = nxt_is_limit; // see (R01)
  wire nxt_fault = nxt_is_retry || nxt_is_latched; // see (R06) (R09) (R11)
  // Power good gated by the switch so a back-fed output cannot report good
  wire nxt_pg = pg_ff && nxt_sw_on; // see (R07)

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_ff <= lsw_pkg::ST_OFF;
      cnt_ff <= lsw_pkg::TICK_CNT_RST;
      en_prev_ff <= 1'b0;
      ot_seen_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      en_prev_ff <= en_ff;
      ot_seen_ff <= nxt_ot_seen;
    end
  end

  // Open-drain data stays low; only the enables move, so a pin never drives high
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      SWITCH_ON <= 1'b0;
      CURRENT_LIMIT <= 1'b0;
      FAULT_FLAG_N_O <= 1'b0;
      FAULT_FLAG_N_OE_N <= 1'b1;
      POWER_GOOD_OUT_O <= 1'b0;
      POWER_GOOD_OUT_OE_N <= 1'b1;
    end else begin
      SWITCH_ON <= nxt_sw_on;
      CURRENT_LIMIT <= nxt_limit;
      FAULT_FLAG_N_O <= 1'b0;
      FAULT_FLAG_N_OE_N <= ~nxt_fault; // see (R06)
      POWER_GOOD_OUT_O <= 1'b0;
      POWER_GOOD_OUT_OE_N <= ~nxt_pg; // see (R07)
    end
  end
endmodule : load_switch_fault_controller

//--- tb/lsw_monitor.sv
// Assertion checker for the load switch fault controller
`timescale 1ns/1ps
module lsw_monitor #(
  parameter bit AUTO_RETRY = 1'b1,
  parameter int unsigned BLANK_TICKS = 5,
  parameter int unsigned RETRY_TICKS = 10
) (
  // Clock, reset and inputs
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic EN,
  input wire logic OVER_CURRENT,
  input wire logic OVER_TEMPERATURE,
  input wire logic VOUT_ABOVE_90PCT,
  // Outputs
  input wire logic SWITCH_ON,
  input wire logic CURRENT_LIMIT,
  input wire logic FAULT_FLAG_N_O,
  input wire logic FAULT_FLAG_N_OE_N,
  input wire logic POWER_GOOD_OUT_O,
  input wire logic POWER_GOOD_OUT_OE_N
);
  // Tick is 250 cycles; retry bounds allow one tick of phase slack, the blanking minimum two cycles, the blanking maximum two ticks
  int lim_ff;
  int cool_ff;
  always_ff @(posedge REF_CLK) begin
    lim_ff <= (!RST_N || !CURRENT_LIMIT) ? 0 : lim_ff + 1;
    cool_ff <= (!RST_N || FAULT_FLAG_N_OE_N || OVER_TEMPERATURE) ? 0 : cool_ff + 1;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  a_limit_now: assert property ((SWITCH_ON && EN && OVER_CURRENT
    && !OVER_TEMPERATURE)[*7] |-> CURRENT_LIMIT) else $error("no limit");
  a_blank_min: assert property ($fell(CURRENT_LIMIT) && !FAULT_FLAG_N_OE_N
    && !OVER_TEMPERATURE |-> $past(lim_ff) >= BLANK_TICKS * 250 - 2) else $error("early off");
  a_blank_max: assert property (lim_ff <= (BLANK_TICKS + 2) * 250)
    else $error("late off");
  a_retry_min: assert property ($rose(FAULT_FLAG_N_OE_N) && AUTO_RETRY |->
    $past(cool_ff) >= (RETRY_TICKS - 1) * 250) else $error("early retry");
  a_retry_max: assert property (AUTO_RETRY |->
    cool_ff <= (RETRY_TICKS + 1) * 250 + 8) else $error("late release");
  a_latch_holds: assert property ((!AUTO_RETRY && !FAULT_FLAG_N_OE_N && EN)[*8]
    |=> !FAULT_FLAG_N_OE_N && !SWITCH_ON) else $error("latch lost");
  a_hot_off: assert property (OVER_TEMPERATURE[*8] |-> !SWITCH_ON)
    else $error("on while hot");
  a_flag_off: assert property (!FAULT_FLAG_N_OE_N && $past(!FAULT_FLAG_N_OE_N)
    |-> !SWITCH_ON) else $error("on in fault");
  a_pg_on: assert property ((VOUT_ABOVE_90PCT && SWITCH_ON)[*8]
    |-> !POWER_GOOD_OUT_OE_N) else $error("power good missing");
  a_pg_off: assert property ((!VOUT_ABOVE_90PCT)[*8] |-> POWER_GOOD_OUT_OE_N)
    else $error("power good while low");
  a_pg_gated: assert property (!POWER_GOOD_OUT_OE_N |-> SWITCH_ON)
    else $error("power good while off");
  a_od_data: assert property (!FAULT_FLAG_N_O && !POWER_GOOD_OUT_O)
    else $error("open drain data high");
endmodule : lsw_monitor
bind load_switch_fault_controller lsw_monitor #(.AUTO_RETRY(AUTO_RETRY),
  .BLANK_TICKS(BLANK_TICKS), .RETRY_TICKS(RETRY_TICKS)) i_lsw_monitor (.REF_CLK(REF_CLK),
  .RST_N(RST_N), .EN(EN), .OVER_CURRENT(OVER_CURRENT), .OVER_TEMPERATURE(OVER_TEMPERATURE),
  .VOUT_ABOVE_90PCT(VOUT_ABOVE_90PCT), .SWITCH_ON(SWITCH_ON), .CURRENT_LIMIT(CURRENT_LIMIT),
  .FAULT_FLAG_N_O(FAULT_FLAG_N_O), .FAULT_FLAG_N_OE_N(FAULT_FLAG_N_OE_N),
  .POWER_GOOD_OUT_O(POWER_GOOD_OUT_O), .POWER_GOOD_OUT_OE_N(POWER_GOOD_OUT_OE_N));

//--- tb/lsw_host_model.sv
// Host model: drives enable, reads the pulled-up fault flag pin
`timescale 1ns/1ps
module lsw_host_model (
  // Clock and bench request
  input wire logic clk,
  input wire logic want_en,
  // Device side
  input wire logic flag_o,
  input wire logic flag_oe_n,
  output logic en = 1'b0,
  output wire logic flag_pin
);
  // Pull-up resistor on the pin: released means high
  assign flag_pin = flag_oe_n ? 1'b1 : flag_o;
  always @(posedge clk) en <= want_en;
endmodule : lsw_host_model

//--- tb/load_switch_fault_controller_tb_top.sv
// Testbench: auto-retry (index 1) and latching (index 0) controllers side by side
`timescale 1ns/1ps
module load_switch_fault_controller_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, want_en = 1'b0, oc = 1'b0, ot = 1'b0, vout = 1'b0;
  wire logic [1:0] en, sw, fo, foe, fpin;
  int failures = 0, check_count = 0;
  logic [3:0] exp_q[$];
  event smp;
  always #2 clk = ~clk;
  for (genvar g = 0; g < 2; g++) begin : gv
    // Short counts keep the run small: 5 and 10 ticks of 250 cycles
    load_switch_fault_controller #(.AUTO_RETRY(g == 1), .BLANK_TICKS(5), .RETRY_TICKS(10))
      i_load_switch_fault_controller (.REF_CLK(clk), .RST_N(rst_n), .EN(en[g]),
      .OVER_CURRENT(oc), .OVER_TEMPERATURE(ot), .VOUT_ABOVE_90PCT(vout), .SWITCH_ON(sw[g]),
      .CURRENT_LIMIT(), .FAULT_FLAG_N_O(fo[g]), .FAULT_FLAG_N_OE_N(foe[g]),
      .POWER_GOOD_OUT_O(), .POWER_GOOD_OUT_OE_N());
    lsw_host_model i_lsw_host_model (.clk(clk), .want_en(want_en), .flag_o(fo[g]),
      .flag_oe_n(foe[g]), .en(en[g]), .flag_pin(fpin[g]));
  end
  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    check_count++;
    if (seen !== want) begin
      failures++;
      $display("BAD %0t: saw %b want %b", $time, seen, want);
    end
  endtask : check
  // Note expectation, wait, then sample past the edge so updates have landed
  task automatic step(input logic [3:0] e, input int n);
    exp_q.push_back(e);
    repeat (n) @(posedge clk);
    #1 -> smp;
    @(posedge clk);
    vout <= 1'($urandom);
  endtask : step
  always @(smp) check({sw, fpin}, exp_q.pop_front());
  task automatic final_report;
    $display("Checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    final_report();
  end
  initial begin
    void'($urandom(89193));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    want_en <= 1'b1;
    step(4'hF, 20);
    want_en <= 1'b0;
    step(4'h3, 20);
    want_en <= 1'b1;
    step(4'hF, 20);
    oc <= 1'b1;
    step(4'hF, $urandom_range(1000, 20));
    oc <= 1'b0;
    step(4'hF, 20);
    oc <= 1'b1;
    step(4'hF, 1100);
    step(4'h0, 500);
    oc <= 1'b0;
    step(4'h0, 2000);
    step(4'hA, 900);
    want_en <= 1'b0;
    step(4'h3, 20);
    want_en <= 1'b1;
    step(4'hF, 20);
    ot <= 1'b1;
    step(4'h0, 20);
    step(4'h0, 3000);
    ot <= 1'b0;
    step(4'h0, 2000);
    step(4'hA, 900);
    final_report();
  end
endmodule : load_switch_fault_controller_tb_top
